// >>> trio_pkg.sv
// Constants and types shared by the terminal run command and I/O logic
package trio_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_IN = 9;
  localparam int NUM_OUT = 5;
  localparam int NUM_CH = 14;
  localparam int DLY_W = 16;
  localparam int FN_W = 4;
  // ****************************************
  // Timing: delays count in 1 ms ticks
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // ****************************************
  // Input function codes, terminal source code and run schemes
  // ****************************************
  localparam logic [3:0] FN_FWD = 4'h2;
  localparam logic [3:0] FN_3LINE = 4'h3;
  localparam logic [3:0] FN_REV = 4'h4;
  localparam logic [3:0] FN_FREE = 4'h6;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  typedef enum logic [1:0] {
    TRIO_TWO_LINE_A = 2'b00,
    TRIO_TWO_LINE_B = 2'b01,
    TRIO_THREE_LINE_A = 2'b10,
    TRIO_THREE_LINE_B = 2'b11
  } trio_scheme_t;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_IN_POL = 8'h04;
  localparam logic [7:0] A_OUT_POL_A = 8'h08;
  localparam logic [7:0] A_OUT_POL_B = 8'h0C;
  localparam logic [7:0] A_FUNC_LO = 8'h10;
  localparam logic [7:0] A_FUNC_HI = 8'h14;
  localparam logic [7:0] A_OUT_REQ = 8'h18;
  localparam logic [7:0] A_DLY_BASE = 8'h20;
  localparam logic [7:0] A_IN_STATE = 8'h60;
  localparam logic [7:0] A_OUT_STATE = 8'h64;
  localparam logic [7:0] A_RUN_STAT = 8'h68;
  localparam logic [7:0] A_IRQ_STAT = 8'h6C;
  localparam logic [7:0] A_IRQ_MASK = 8'h70;
  // ****************************************
  // Field positions, reset values and bus response codes
  // ****************************************
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_SRC_LSB = 4;
  localparam int DLY_OFF_LSB = 16;
  localparam int IN_COND_LSB = 16;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_RUN_ON = 1;
  localparam int IRQ_RUN_OFF = 2;
  localparam int IRQ_FREE = 3;
  localparam logic [31:0] RST_CTRL = 32'h0000_0010;
  localparam logic [35:0] RST_FUNC = 36'h0_0000_0642;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> trio_dly_if.sv
// Interface between the channel control and one on/off delay filter
`timescale 1ns/1ps
`default_nettype none
interface trio_dly_if;
  logic [15:0] on_dly;
  logic [15:0] off_dly;
  logic in_lvl;
  logic out_lvl;
  modport ctl (output on_dly, output off_dly, output in_lvl, input out_lvl);
  modport flt (input on_dly, input off_dly, input in_lvl, output out_lvl);
endinterface
`default_nettype wire

// >>> trio_delay.sv
// On/off delay filter for one digital channel
`timescale 1ns/1ps
`default_nettype none
module trio_delay (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  trio_dly_if.flt dl
);
  logic state_q;
  logic [15:0] cnt_q;
  logic [15:0] need;
  // A rising change waits the on delay, a falling change the off delay
  assign need = dl.in_lvl ? dl.on_dly : dl.off_dly;
  assign dl.out_lvl = state_q;

  // A level that drops back early restarts the count, so it is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (dl.in_lvl == state_q) begin
      cnt_q <= 16'h0000; // (R11)
    end else if (need == 16'h0000 || (tick && cnt_q + 16'h0001 >= need)) begin
      state_q <= dl.in_lvl; // (R11)
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  hold_stable_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R11)
    (dl.in_lvl == state_q) |=> $stable(state_q))
    else $error("delay output moved while input matched it");
endmodule
`default_nettype wire

// >>> trio_top.sv
// Terminal run command decoding and digital I/O conditioning with AXI4-Lite registers
// Notes on behaviour
// (R1) Scheme 0: forward input runs forward, reverse input runs reverse.
// (R2) Scheme 1: forward input enables running, reverse input chooses direction.
// (R3) Scheme 2: three-line input is stop, forward input starts, reverse picks direction.
// (R4) Scheme 3: three-line input is stop, forward or reverse starts, each with its direction.
// (R5) An input with function 3 is the three-line stop input.
// (R6) Run commands are taken only when the command source is 1, terminals.
// (R7) An input with function 2 is the forward run command once conditioned active.
// (R8) An input with function 6 gives a free stop once conditioned active; the code gives it only under terminal control.
// (R9) A set bit of the input polarity mask inverts that input.
// (R10) Under terminal control, forward run together with free stop raises an alarm.
// (R11) Each input has on and off delays; a level held shorter is ignored.
// (R12) Seven ordinary inputs and two fast inputs are conditioned alike.
// (R13) Two fast outputs and three relay outputs each have on and off delays.
// (R14) Each output has selectable polarity; negative logic drives 0 for active.
// (R15) A readable output status shows each output after delay and polarity.
// (R16) Three-line run latches on a start pulse and clears on stop; scheme 0 both inputs stop.
`timescale 1ns/1ps
`default_nettype none
module trio_top #(
  parameter int TICK_CYCLES = trio_pkg::TICK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [6:0] term_inputs,
  input wire logic fast_input_one,
  input wire logic fast_input_two,
  output logic fast_output_one,
  output logic fast_output_two,
  output logic [2:0] relay_outputs,
  output logic run_cmd,
  output logic reverse_dir,
  output logic free_stop,
  output logic run_alarm,
  output logic irq
);
  // ****************************************
  // Registers and helpers
  // ****************************************
  logic [31:0] ctrl_q;
  logic [8:0] in_pol_q;
  logic [1:0] out_pol_a_q;
  logic [2:0] out_pol_b_q;
  logic [35:0] func_q;
  logic [4:0] out_req_q;
  logic [31:0] dly_q [trio_pkg::NUM_CH];
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [8:0] in_meta_q, in_sync_q, cond;
  logic [4:0] out_dly, out_pins_q, out_pol;
  logic [15:0] tick_cnt_q;
  logic tick_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic run_q, dir_q, free_q, alarm_q, latch_q;
  logic fwd, rev, tls, fstop, term_en, fwd_q, rev_q;
  logic run_d, dir_d;
  logic [3:0] ev;
  trio_pkg::trio_scheme_t scheme;

  // Byte-lane merge used by every writable register except the interrupt status
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // True when any conditioned input carries the given function code
  function automatic logic any_fn(input logic [35:0] f, input logic [8:0] c,
                                  input logic [3:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < trio_pkg::NUM_IN; i++) begin
      if (c[i] && f[i*4 +: 4] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ****************************************
  // Tick divider and input synchronisers
  // ****************************************
  // One-cycle enable every millisecond paces all delay counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Pins are asynchronous; two stages before any logic looks at them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta_q <= 9'h000;
      in_sync_q <= 9'h000;
    end else begin
      in_meta_q <= {fast_input_two, fast_input_one, term_inputs}; // (R12)
      in_sync_q <= in_meta_q;
    end
  end

  // ****************************************
  // Delay channels: 9 inputs then 5 outputs
  // ****************************************
  assign out_pol = {out_pol_b_q, out_pol_a_q};
  for (genvar g = 0; g < trio_pkg::NUM_CH; g++) begin : g_ch
    trio_dly_if dl ();
    assign dl.on_dly = dly_q[g][15:0];
    assign dl.off_dly = dly_q[g][31:trio_pkg::DLY_OFF_LSB];
    if (g < trio_pkg::NUM_IN) begin : g_in
      assign dl.in_lvl = in_sync_q[g] ^ in_pol_q[g]; // (R9)
      assign cond[g] = dl.out_lvl; // (R11)
    end else begin : g_out
      assign dl.in_lvl = out_req_q[g - trio_pkg::NUM_IN];
      assign out_dly[g - trio_pkg::NUM_IN] = dl.out_lvl; // (R13)
    end
    trio_delay u_dly (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick_q),
      .dl(dl)
    );
  end

  // Polarity after delay, registered so the pins come straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_pins_q <= 5'h00;
    end else begin
      out_pins_q <= out_dly ^ out_pol; // (R14)
    end
  end
  assign fast_output_one = out_pins_q[0];
  assign fast_output_two = out_pins_q[1];
  assign relay_outputs = out_pins_q[4:2];

  // ****************************************
  // Run command decoding
  // ****************************************
  assign scheme = trio_pkg::trio_scheme_t'(ctrl_q[trio_pkg::CTRL_SCHEME_LSB +: 2]);
  assign term_en = ctrl_q[trio_pkg::CTRL_SRC_LSB +: 2] == trio_pkg::SRC_TERMINAL; // (R6)
  assign fwd = any_fn(func_q, cond, trio_pkg::FN_FWD); // (R7)
  assign rev = any_fn(func_q, cond, trio_pkg::FN_REV);
  assign tls = any_fn(func_q, cond, trio_pkg::FN_3LINE); // (R5)
  assign fstop = any_fn(func_q, cond, trio_pkg::FN_FREE); // (R8)

  // Next run and direction per scheme; free stop and source gate the run only
  always_comb begin
    run_d = 1'b0;
    dir_d = dir_q;
    unique case (scheme)
      trio_pkg::TRIO_TWO_LINE_A: begin
        run_d = fwd ^ rev; // (R1) (R16)
        dir_d = rev & ~fwd; // (R1)
      end
      trio_pkg::TRIO_TWO_LINE_B: begin
        run_d = fwd; // (R2)
        dir_d = rev; // (R2)
      end
      trio_pkg::TRIO_THREE_LINE_A: begin
        run_d = tls & (latch_q | (fwd & ~fwd_q)); // (R3) (R16)
        dir_d = rev; // (R3)
      end
      trio_pkg::TRIO_THREE_LINE_B: begin
        run_d = tls & (latch_q | (fwd & ~fwd_q) | (rev & ~rev_q)); // (R4) (R16)
        if (fwd & ~fwd_q) begin
          dir_d = 1'b0; // (R4)
        end else if (rev & ~rev_q) begin
          dir_d = 1'b1; // (R4)
        end
      end
    endcase
    if (!term_en || fstop) begin
      run_d = 1'b0; // (R6) (R8)
    end
  end

  // The latch only matters in three-line schemes; others keep it clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      dir_q <= 1'b0;
      latch_q <= 1'b0;
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      free_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      run_q <= run_d;
      dir_q <= dir_d;
      latch_q <= run_d & scheme[1]; // (R16)
      fwd_q <= fwd;
      rev_q <= rev;
      free_q <= term_en & fstop; // (R8)
      alarm_q <= term_en & fwd & fstop; // (R10)
    end
  end
  assign run_cmd = run_q;
  assign reverse_dir = dir_q;
  assign free_stop = free_q;
  assign run_alarm = alarm_q;

  // ****************************************
  // Interrupt status
  // ****************************************
  assign ev = {term_en & fstop & ~free_q, ~run_d & run_q, run_d & ~run_q,
               term_en & fwd & fstop & ~alarm_q};
  // Write one to clear; a new event in the same cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      if (aw_got_q && w_got_q && !s_axi_bvalid && awaddr_q == trio_pkg::A_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~(wdata_q[3:0] & {4{wstrb_q[0]}})) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // Address and data are captured in either order; the write happens once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= trio_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > trio_pkg::A_IRQ_MASK || awaddr_q[1:0] != 2'b00
                        || (awaddr_q > 8'h54 && awaddr_q < trio_pkg::A_IN_STATE)
                        || (awaddr_q > trio_pkg::A_OUT_REQ && awaddr_q < trio_pkg::A_DLY_BASE))
                       ? trio_pkg::RESP_SLVERR : trio_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register stores; status words other than the interrupt status are read only and ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= trio_pkg::RST_CTRL;
      in_pol_q <= 9'h000;
      out_pol_a_q <= 2'h0;
      out_pol_b_q <= 3'h0;
      func_q <= trio_pkg::RST_FUNC;
      out_req_q <= 5'h00;
      irq_mask_q <= 4'h0;
      for (int i = 0; i < trio_pkg::NUM_CH; i++) begin
        dly_q[i] <= 32'h0000_0000;
      end
    end else if (aw_got_q && w_got_q && !s_axi_bvalid) begin
      unique case (awaddr_q)
        trio_pkg::A_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0033;
        trio_pkg::A_IN_POL: in_pol_q <= 9'(merge({23'h0, in_pol_q}, wdata_q, wstrb_q)); // (R9)
        trio_pkg::A_OUT_POL_A: out_pol_a_q <= 2'(merge(32'h0, wdata_q, wstrb_q)); // (R14)
        trio_pkg::A_OUT_POL_B: out_pol_b_q <= 3'(merge(32'h0, wdata_q, wstrb_q)); // (R14)
        trio_pkg::A_FUNC_LO: func_q[31:0] <= merge(func_q[31:0], wdata_q, wstrb_q);
        trio_pkg::A_FUNC_HI: func_q[35:32] <= 4'(merge({28'h0, func_q[35:32]}, wdata_q, wstrb_q));
        trio_pkg::A_OUT_REQ: out_req_q <= 5'(merge({27'h0, out_req_q}, wdata_q, wstrb_q));
        trio_pkg::A_IRQ_MASK: irq_mask_q <= 4'(merge({28'h0, irq_mask_q}, wdata_q, wstrb_q));
        default: begin
          for (int i = 0; i < trio_pkg::NUM_CH; i++) begin
            if (awaddr_q == trio_pkg::A_DLY_BASE + 8'(4 * i)) begin
              dly_q[i] <= merge(dly_q[i], wdata_q, wstrb_q); // (R11) (R13)
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  // One read at a time; arready drops until the data beat is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= trio_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= trio_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        trio_pkg::A_CTRL: s_axi_rdata <= ctrl_q;
        trio_pkg::A_IN_POL: s_axi_rdata <= {23'h0, in_pol_q};
        trio_pkg::A_OUT_POL_A: s_axi_rdata <= {30'h0, out_pol_a_q};
        trio_pkg::A_OUT_POL_B: s_axi_rdata <= {29'h0, out_pol_b_q};
        trio_pkg::A_FUNC_LO: s_axi_rdata <= func_q[31:0];
        trio_pkg::A_FUNC_HI: s_axi_rdata <= {28'h0, func_q[35:32]};
        trio_pkg::A_OUT_REQ: s_axi_rdata <= {27'h0, out_req_q};
        trio_pkg::A_IN_STATE: s_axi_rdata <= {7'h0, cond, 7'h0, in_sync_q};
        trio_pkg::A_OUT_STATE: s_axi_rdata <= {27'h0, out_pins_q}; // (R15)
        trio_pkg::A_RUN_STAT: s_axi_rdata <= {28'h0, alarm_q, free_q, dir_q, run_q};
        trio_pkg::A_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_q};
        trio_pkg::A_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_q};
        default: begin
          s_axi_rresp <= trio_pkg::RESP_SLVERR;
          for (int i = 0; i < trio_pkg::NUM_CH; i++) begin
            if (s_axi_araddr == trio_pkg::A_DLY_BASE + 8'(4 * i)) begin
              s_axi_rdata <= dly_q[i];
              s_axi_rresp <= trio_pkg::RESP_OKAY;
            end
          end
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence fwd_start_s;
    term_en && !fstop && tls && scheme == trio_pkg::TRIO_THREE_LINE_A && fwd && !fwd_q;
  endsequence
  sequence three_stop_s;
    scheme[1] && !tls;
  endsequence

  mode0_fwd_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R1)
    (term_en && !fstop && scheme == trio_pkg::TRIO_TWO_LINE_A && fwd && !rev)
      |=> run_q && !dir_q) else $error("scheme 0 forward not run forward");
  mode0_both_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R16)
    (scheme == trio_pkg::TRIO_TWO_LINE_A && fwd && rev) |=> !run_q)
    else $error("scheme 0 both inputs did not stop");
  mode1_dir_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R2)
    (term_en && !fstop && scheme == trio_pkg::TRIO_TWO_LINE_B && fwd)
      |=> run_q && dir_q == $past(rev)) else $error("scheme 1 direction wrong");
  three_latch_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R3)
    fwd_start_s |=> run_q) else $error("three-line start not latched");
  three_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R4)
    three_stop_s |=> !run_q) else $error("three-line stop ignored");
  source_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R6)
    !term_en |=> !run_q && !alarm_q) else $error("run outside terminal source");
  free_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R8)
    (term_en && fstop) |=> free_q && !run_q) else $error("free stop not applied");
  run_alarm_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R10)
    (term_en && fwd && fstop && !alarm_q) |=> alarm_q && irq_stat_q[trio_pkg::IRQ_ALARM])
    else $error("alarm not raised");
  out_polarity_a: assert property (@(posedge aclk) disable iff (!aresetn) // (R14)
    ##1 out_pins_q == $past(out_dly ^ out_pol)) else $error("output polarity wrong");
endmodule
`default_nettype wire

// >>> trio_switches.sv
// Model of the external switches wired to the digital input terminals
`timescale 1ns/1ps
`default_nettype none
module trio_switches (
  input wire logic [8:0] closed,
  output logic [6:0] term_inputs,
  output logic fast_input_one,
  output logic fast_input_two
);
  // A closed contact drives its input high; the pins are never left floating
  assign term_inputs = closed[6:0];
  assign fast_input_one = closed[7];
  assign fast_input_two = closed[8];
endmodule
`default_nettype wire

// >>> trio_top_tb.sv
// Self-checking testbench for the terminal run command and I/O block
`timescale 1ns/1ps
`default_nettype none
module trio_top_tb;
  typedef struct packed {logic [1:0] s; logic [8:0] p; logic [3:0] e; logic [3:0] m;} trio_row_t;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, f1, f2, run, dir, fst, alm, irq;
  logic [1:0] bresp, rresp, rs, bs;
  logic [3:0] st;
  logic [2:0] relays;
  logic [8:0] closed = 9'h000;
  wire logic [6:0] term;
  wire logic h1, h2;
  int failures = 0, checked = 0, cyc = 0, n;
  trio_row_t rows [15];
  trio_top #(.TICK_CYCLES(4)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .term_inputs(term), .fast_input_one(h1), .fast_input_two(h2),
    .fast_output_one(f1), .fast_output_two(f2), .relay_outputs(relays), .run_cmd(run),
    .reverse_dir(dir), .free_stop(fst), .run_alarm(alm), .irq(irq));
  trio_switches u_sw (.closed(closed), .term_inputs(term), .fast_input_one(h1),
    .fast_input_two(h2));
  // ****************************************
  // Clock, timeout and reporting
  // ****************************************
  always #20 aclk = ~aclk;
  // Ceiling well above the roughly 500 cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // ****************************************
  // Register bus master
  // ****************************************
  // Address and data offered together; each released only at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 1'h0;
        awvalid <= 1'h0;
      end
      if (pw && wready) begin
        pw = 1'h0;
        wvalid <= 1'h0;
      end
    end while (bvalid !== 1'h1);
    bs = bresp;
    bready <= 1'h0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  // Sync, zero-delay filter and output flop settle well inside eight cycles
  task automatic set_pins(input logic [8:0] v);
    @(posedge aclk);
    closed <= v;
    repeat (8) @(posedge aclk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows = '{'{2'h0, 9'h000, 4'h0, 4'hF}, '{2'h0, 9'h001, 4'h1, 4'hF}, '{2'h0, 9'h002, 4'h3, 4'hF},
      '{2'h0, 9'h003, 4'h0, 4'h1}, '{2'h0, 9'h005, 4'hC, 4'hD}, '{2'h1, 9'h001, 4'h1, 4'hF},
      '{2'h1, 9'h003, 4'h3, 4'hF}, '{2'h1, 9'h002, 4'h0, 4'h1}, '{2'h2, 9'h008, 4'h0, 4'h1},
      '{2'h2, 9'h009, 4'h1, 4'hF}, '{2'h2, 9'h00A, 4'h3, 4'hF}, '{2'h2, 9'h000, 4'h0, 4'h1},
      '{2'h3, 9'h008, 4'h0, 4'h1}, '{2'h3, 9'h00A, 4'h3, 4'hF}, '{2'h3, 9'h000, 4'h0, 4'h1}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rdreg(trio_pkg::A_CTRL);
    chk(rd, trio_pkg::RST_CTRL, "ctrl reset");
    rdreg(trio_pkg::A_FUNC_LO);
    chk(rd, trio_pkg::RST_FUNC[31:0], "function reset");
    rdreg(8'hFC);
    chk(32'(rs), 32'(trio_pkg::RESP_SLVERR), "unmapped read");
    for (int i = 0; i < 14; i++) wr(trio_pkg::A_DLY_BASE + 8'(4 * i), 32'h0);
    wr(trio_pkg::A_FUNC_LO, 32'h0000_3642);
    chk(32'(bs), 32'(trio_pkg::RESP_OKAY), "write okay");
    // A hole between the output request and the delay words refuses writes
    wr(8'h1C, 32'h0);
    chk(32'(bs), 32'(trio_pkg::RESP_SLVERR), "unmapped write");
    // Command table: each row builds on the state left by the one before
    for (int i = 0; i < 15; i++) begin
      wr(trio_pkg::A_CTRL, 32'h10 | 32'(rows[i].s));
      set_pins(rows[i].p);
      st = {alm, fst, dir, run} & rows[i].m;
      chk(32'(st), 32'(rows[i].e & rows[i].m), "row");
    end
    // Source other than terminals ignores every terminal command except the direction set by reverse
    wr(trio_pkg::A_CTRL, 32'h0);
    set_pins(9'h005);
    chk(32'({alm, fst, dir, run}), 32'h0, "source off");
    wr(trio_pkg::A_CTRL, 32'h10);
    set_pins(9'h000);
    wr(trio_pkg::A_IN_POL, 32'h4);
    repeat (8) @(posedge aclk);
    chk(32'(fst), 32'h1, "inverted free stop");
    wr(trio_pkg::A_IN_POL, 32'h0);
    // Interrupt raised, masked, unmasked and cleared while the alarm holds
    wr(trio_pkg::A_IRQ_STAT, 32'hF);
    wr(trio_pkg::A_IRQ_MASK, 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0, "irq idle");
    set_pins(9'h005);
    chk(32'(irq), 32'h1, "irq on alarm");
    wr(trio_pkg::A_IRQ_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0, "irq masked");
    wr(trio_pkg::A_IRQ_MASK, 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(trio_pkg::A_IRQ_STAT, 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0, "irq cleared");
    set_pins(9'h000);
    // A pulse shorter than the on delay is dropped, a held level passes late
    // Five ticks of on delay outlast the nine cycles the pulse is seen
    wr(trio_pkg::A_DLY_BASE, 32'h5);
    set_pins(9'h001);
    chk(32'(run), 32'h0, "pulse held off");
    @(posedge aclk);
    closed <= 9'h000;
    repeat (30) @(posedge aclk);
    chk(32'(run), 32'h0, "short pulse");
    @(posedge aclk);
    closed <= 9'h001;
    n = 0;
    while (run !== 1'h1 && n < 80) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n >= 16 && n < 80), 32'h1, "on delay");
    set_pins(9'h180);
    rdreg(trio_pkg::A_IN_STATE);
    chk(rd, 32'h0180_0180, "fast inputs");
    // Outputs: delayed fast output and an inverted relay
    wr(trio_pkg::A_DLY_BASE + 8'h24, 32'h2);
    wr(trio_pkg::A_OUT_POL_B, 32'h1);
    wr(trio_pkg::A_OUT_REQ, 32'h1);
    repeat (2) @(posedge aclk);
    chk(32'(f1), 32'h0, "output held off");
    n = 0;
    while (f1 !== 1'h1 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    chk(32'({relays, f2, f1}), 32'h5, "output pins");
    rdreg(trio_pkg::A_OUT_STATE);
    chk(rd, 32'h5, "output state");
    close_out();
  end
endmodule
`default_nettype wire
